//--- ptxoe_top.sv
// Behaviour
// RL1: M-byte source field picks HDLC or registers
// RL2: F1 source: trace, HDLC, register; 11 reserved
// RL3: M code 00 with F1 01 gives undefined F1
// RL4: F1 and HDLC M byte may differ
// RL5: REI automatic from BIP-8 unless defeated
// RL6: Injected REI is 1h or 8h
// RL7: REI injection single or every frame
// RL8: REI injected only while enabled
// RL9: Parity error flips one or eight B1 bits
// RL10: Parity injection single or continuous
// RL11: Parity injected only while enabled
// RL12: Framing error flips one or eight bits
// RL13: Framing type selects A1/A2/POI pattern
// RL14: Framing injected only while enabled; the code still flips a matching byte in the cycle after the enable clears
// RL15: Rising single-error bit inserts one error
// RL16: Many toggles before opportunity give one error
// RL17: Trigger select picks register bit or pin
// RL18: Changing trigger select may insert an error
// RL19: Defeated REI uses register REI bits
// RL20: Register F1 byte from upper F1/G1 byte
// RL21: Trigger edges held until matching opportunity; framing drops an edge arriving at its first hit or before its second
// RL22: Control and injection bits reset to zero
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ptxoe_top #(
    parameter int ADDR_W = 9
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic [ADDR_W-1:0]  addr_i,
    input  wire logic [15:0]        wr_data_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [15:0]             rd_data_o,
    input  wire ptxoe_pkg::ptxoe_byte_s stream_i,
    output ptxoe_pkg::ptxoe_byte_s  stream_o,
    input  wire logic [7:0]         hdlc_byte_i,
    output logic                    hdlc_take_o,
    input  wire logic [7:0]         trace_byte_i,
    input  wire logic [3:0]         rx_bip_err_i,
    input  wire logic               manual_error_pin_i
);
    import ptxoe_pkg::*;

    logic [15:0] ctrl_r;
    logic [15:0] errinj_r;
    logic [15:0] f1g1_r;
    logic [15:0] m1m2_r;
    logic [15:0] z12_r;
    logic [15:0] z34_r;
    logic [15:0] z56_r;
    logic        pin_s1_r;
    logic        pin_s2_r;
    logic        pin_s3_r;
    logic        pin_lvl_r;
    logic        trig_prev_r;
    logic        rei_pend_r;
    logic        par_pend_r;
    ptxoe_frm_e  frm_r;
    logic        trig_lvl;
    logic        trig_edge;
    logic        rei_act;
    logic        par_act;
    logic        frm_hit;
    logic [7:0]  flip;
    logic [7:0]  g1_byte;
    logic [7:0]  out_byte;
    logic        take_nxt;
    logic [7:0]  idx;
    logic        hit_ok;

    // Field views of the control registers
    wire logic [1:0] m_byte_source_sel     = ctrl_r[PTXOE_M_SRC_LSB +: 2];
    wire logic [1:0] f1_source_sel         = ctrl_r[PTXOE_F1_SRC_LSB +: 2];
    wire logic       remote_error_auto_off = ctrl_r[PTXOE_AUTO_OFF_BIT];
    wire logic       remote_error_max_sel   = errinj_r[PTXOE_REI_MAX_BIT];
    wire logic       remote_error_continuous = errinj_r[PTXOE_REI_CONT_BIT];
    wire logic       remote_error_inject_en  = errinj_r[PTXOE_REI_EN_BIT];
    wire logic       parity_block_error_sel  = errinj_r[PTXOE_PAR_BLK_BIT];
    wire logic       parity_continuous_sel   = errinj_r[PTXOE_PAR_CONT_BIT];
    wire logic       parity_inject_en        = errinj_r[PTXOE_PAR_EN_BIT];
    wire logic       framing_whole_byte_sel  = errinj_r[PTXOE_FRM_BYTE_BIT];
    wire logic [1:0] framing_error_type      = errinj_r[PTXOE_FRM_TYPE_LSB +: 2];
    wire logic       framing_inject_en       = errinj_r[PTXOE_FRM_EN_BIT];
    wire logic       single_error_trigger    = errinj_r[PTXOE_SINGLE_BIT];
    wire logic       trigger_source_sel      = errinj_r[PTXOE_TRIG_SRC_BIT];
    wire logic [7:0] f1_register_byte        = f1g1_r[15:8];
    wire logic [3:0] remote_error_value      = f1g1_r[7:4];

    // Word index of a bus address, if aligned
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = 8'(a[ADDR_W-1:2]);
    endfunction

    assign idx    = word_idx(addr_i);
    assign hit_ok = (addr_i[1:0] == 2'h0);

    // Register writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r   <= PTXOE_REG_RESET; // RL22
            errinj_r <= PTXOE_REG_RESET; // RL22
            f1g1_r   <= PTXOE_REG_RESET;
            m1m2_r   <= PTXOE_REG_RESET;
            z12_r    <= PTXOE_REG_RESET;
            z34_r    <= PTXOE_REG_RESET;
            z56_r    <= PTXOE_REG_RESET;
        end else if (wr_i && hit_ok) begin
            unique case (idx)
                PTXOE_IDX_CTRL:   ctrl_r   <= wr_data_i & PTXOE_CTRL_MASK;
                PTXOE_IDX_ERRINJ: errinj_r <= wr_data_i & PTXOE_ERRINJ_MASK;
                PTXOE_IDX_F1G1:   f1g1_r   <= wr_data_i;
                PTXOE_IDX_M1M2:   m1m2_r   <= wr_data_i;
                PTXOE_IDX_Z1Z2:   z12_r    <= wr_data_i;
                PTXOE_IDX_Z3Z4:   z34_r    <= wr_data_i;
                PTXOE_IDX_Z5Z6:   z56_r    <= wr_data_i;
                default: ;
            endcase
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_i && hit_ok) begin
            unique case (idx)
                PTXOE_IDX_CTRL:   rd_data_o <= ctrl_r;
                PTXOE_IDX_ERRINJ: rd_data_o <= errinj_r;
                PTXOE_IDX_F1G1:   rd_data_o <= f1g1_r;
                PTXOE_IDX_M1M2:   rd_data_o <= m1m2_r;
                PTXOE_IDX_Z1Z2:   rd_data_o <= z12_r;
                PTXOE_IDX_Z3Z4:   rd_data_o <= z34_r;
                PTXOE_IDX_Z5Z6:   rd_data_o <= z56_r;
                PTXOE_IDX_STATUS: rd_data_o <= {9'h000, pin_lvl_r, frm_r,
                                                par_pend_r, rei_pend_r, trig_lvl};
                default:          rd_data_o <= 16'h0000;
            endcase
        end else begin
            rd_data_o <= 16'h0000;
        end
    end

    // Pin synchroniser; level moves once stages two and three agree
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_r  <= 1'b0;
            pin_s2_r  <= 1'b0;
            pin_s3_r  <= 1'b0;
            pin_lvl_r <= 1'b0;
        end else begin
            pin_s1_r <= manual_error_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_lvl_r <= pin_s3_r; // RL21
            end
        end
    end

    // Trigger source and rising-edge detect
    assign trig_lvl  = trigger_source_sel ? pin_lvl_r : single_error_trigger; // RL17 RL18
    assign trig_edge = trig_lvl && !trig_prev_r; // RL15

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig_lvl;
        end
    end

    // Slot strobes
    wire logic at_g1  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_G1);
    wire logic at_b1  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_B1);
    wire logic at_a1  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_A1);
    wire logic at_a2  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_A2);
    wire logic at_poi = stream_i.valid && (stream_i.slot == PTXOE_SLOT_POI);
    wire logic at_f1  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_F1);
    wire logic at_m1  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_M1);
    wire logic at_m2  = stream_i.valid && (stream_i.slot == PTXOE_SLOT_M2);

    // Pending REI request; a new edge wins over the clear at G1
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rei_pend_r <= 1'b0;
        end else if (!remote_error_inject_en || remote_error_continuous) begin
            rei_pend_r <= 1'b0; // RL8
        end else if (trig_edge) begin
            rei_pend_r <= 1'b1; // RL15 RL16
        end else if (at_g1) begin
            rei_pend_r <= 1'b0; // RL21
        end
    end

    // Pending parity request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            par_pend_r <= 1'b0;
        end else if (!parity_inject_en || parity_continuous_sel) begin
            par_pend_r <= 1'b0; // RL11
        end else if (trig_edge) begin
            par_pend_r <= 1'b1; // RL15 RL16
        end else if (at_b1) begin
            par_pend_r <= 1'b0; // RL21
        end
    end

    assign rei_act = remote_error_inject_en && (remote_error_continuous || rei_pend_r); // RL7 RL8
    assign par_act = parity_inject_en && (parity_continuous_sel || par_pend_r); // RL10 RL11

    // Framing byte that the current state waits for
    always_comb begin
        frm_hit = 1'b0;
        unique case (frm_r)
            PTXOE_FS_ARMED: begin
                unique case (framing_error_type) // RL13
                    PTXOE_SRC_00: frm_hit = at_a1 || at_a2;
                    PTXOE_SRC_01: frm_hit = at_poi;
                    PTXOE_SRC_10: frm_hit = at_a1;
                    PTXOE_SRC_11: frm_hit = at_poi;
                endcase
            end
            PTXOE_FS_SECOND: begin
                frm_hit = (framing_error_type == PTXOE_SRC_10) ? at_a2 : at_poi; // RL13
            end
            PTXOE_FS_IDLE: frm_hit = 1'b0;
            default:       frm_hit = 1'b0;
        endcase
    end

    // Framing injection sequencer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frm_r <= PTXOE_FS_IDLE;
        end else if (!framing_inject_en) begin
            frm_r <= PTXOE_FS_IDLE; // RL14
        end else begin
            unique case (frm_r)
                PTXOE_FS_IDLE: begin
                    if (trig_edge) begin
                        frm_r <= PTXOE_FS_ARMED; // RL15
                    end
                end
                PTXOE_FS_ARMED: begin
                    if (frm_hit) begin
                        frm_r <= framing_error_type[1] ? PTXOE_FS_SECOND
                                                       : PTXOE_FS_IDLE; // RL13
                    end
                end
                PTXOE_FS_SECOND: begin
                    if (frm_hit) begin
                        frm_r <= trig_edge ? PTXOE_FS_ARMED : PTXOE_FS_IDLE;
                    end
                end
                default: frm_r <= PTXOE_FS_IDLE;
            endcase
        end
    end

    // REI nibble and G1 byte
    always_comb begin
        g1_byte = f1g1_r[7:0];
        if (rei_act) begin
            g1_byte[7:4] = remote_error_max_sel ? PTXOE_REI_EIGHT : PTXOE_REI_ONE; // RL6
        end else if (remote_error_auto_off) begin
            g1_byte[7:4] = remote_error_value; // RL5 RL19
        end else begin
            g1_byte[7:4] = rx_bip_err_i; // RL5
        end
    end

    // Outgoing byte selection
    always_comb begin
        out_byte = stream_i.data;
        take_nxt = 1'b0;
        flip     = 8'h00;
        if (at_g1) begin
            out_byte = g1_byte;
        end else if (at_b1) begin
            flip     = parity_block_error_sel ? PTXOE_FLIP_ALL : PTXOE_FLIP_BIT; // RL9
            out_byte = par_act ? (stream_i.data ^ flip) : stream_i.data;
        end else if (at_a1 || at_a2 || at_poi) begin
            flip     = framing_whole_byte_sel ? PTXOE_FLIP_ALL : PTXOE_FLIP_BIT; // RL12
            out_byte = frm_hit ? (stream_i.data ^ flip) : stream_i.data;
        end else if (at_f1) begin
            unique case (f1_source_sel) // RL2
                PTXOE_SRC_00: out_byte = trace_byte_i;
                PTXOE_SRC_01: begin
                    // Undefined when M bytes hold the 128 kHz link
                    out_byte = (m_byte_source_sel == PTXOE_SRC_00) ? 8'h00
                                                                   : hdlc_byte_i; // RL3 RL4
                    take_nxt = (m_byte_source_sel != PTXOE_SRC_00);
                end
                PTXOE_SRC_10: out_byte = f1_register_byte; // RL20
                PTXOE_SRC_11: out_byte = f1_register_byte;
            endcase
        end else if (at_m1) begin
            take_nxt = !m_byte_source_sel[0]; // RL1
            out_byte = take_nxt ? hdlc_byte_i : m1m2_r[7:0];
        end else if (at_m2) begin
            take_nxt = !m_byte_source_sel[1]; // RL1
            out_byte = take_nxt ? hdlc_byte_i : m1m2_r[15:8];
        end
    end

    // Registered stream output and HDLC take pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stream_o    <= '0;
            hdlc_take_o <= 1'b0;
        end else begin
            stream_o.valid <= stream_i.valid;
            stream_o.slot  <= stream_i.slot;
            stream_o.data  <= out_byte;
            hdlc_take_o    <= take_nxt;
        end
    end

    // Checks
    rei_max_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL6
        at_g1 && rei_act && remote_error_max_sel |=> stream_o.data[7:4] == 4'h8)
        else $error("REI max value wrong");
    rei_one_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL6
        at_g1 && rei_act && !remote_error_max_sel |=> stream_o.data[7:4] == 4'h1)
        else $error("REI single value wrong");
    rei_auto_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL5
        at_g1 && !remote_error_inject_en && !remote_error_auto_off
        |=> stream_o.data[7:4] == $past(rx_bip_err_i))
        else $error("Automatic REI not from BIP-8 count");
    rei_reg_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL19
        at_g1 && !remote_error_inject_en && remote_error_auto_off
        |=> stream_o.data == $past(f1g1_r[7:0]))
        else $error("Register REI not inserted");
    par_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL11
        at_b1 && !parity_inject_en |=> stream_o.data == $past(stream_i.data))
        else $error("B1 altered while parity injection off");
    par_blk_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL9
        at_b1 && par_act && parity_block_error_sel
        |=> stream_o.data == ~$past(stream_i.data))
        else $error("B1 block error not all bits");
    par_once_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL16
        par_pend_r && at_b1 && !trig_edge |=> !par_pend_r)
        else $error("Parity request kept after insertion");
    frm_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL14
        !framing_inject_en |=> frm_r == PTXOE_FS_IDLE)
        else $error("Framing sequencer active while disabled");
    f1_reg_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL20
        at_f1 && f1_source_sel == PTXOE_SRC_10 |=> stream_o.data == $past(f1g1_r[15:8]))
        else $error("F1 register byte not inserted");
    m_reg_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL1
        at_m2 && m_byte_source_sel == PTXOE_SRC_11
        |=> stream_o.data == $past(m1m2_r[15:8]) && !hdlc_take_o)
        else $error("M2 not from register");
    trig_pend_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL15
        trig_edge && parity_inject_en && !parity_continuous_sel |=> par_pend_r)
        else $error("Trigger edge not captured");

    rei_inject_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        at_g1 && rei_pend_r);
    frm_second_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        frm_r == PTXOE_FS_SECOND && frm_hit);
    pin_trig_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        trigger_source_sel && trig_edge);
    par_cont_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        at_b1 && parity_continuous_sel && parity_inject_en);

endmodule
`default_nettype wire

//--- ptxoe_pkg.sv
package ptxoe_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] PTXOE_IDX_CTRL   = 8'h50;
    localparam logic [7:0] PTXOE_IDX_ERRINJ = 8'h52;
    localparam logic [7:0] PTXOE_IDX_F1G1   = 8'h54;
    localparam logic [7:0] PTXOE_IDX_M1M2   = 8'h56;
    localparam logic [7:0] PTXOE_IDX_Z1Z2   = 8'h58;
    localparam logic [7:0] PTXOE_IDX_Z3Z4   = 8'h5a;
    localparam logic [7:0] PTXOE_IDX_Z5Z6   = 8'h5c;
    localparam logic [7:0] PTXOE_IDX_STATUS = 8'h5e;

    // Writable bit masks and reset values
    localparam logic [15:0] PTXOE_CTRL_MASK   = 16'h001f;
    localparam logic [15:0] PTXOE_ERRINJ_MASK = 16'h3f3f;
    localparam logic [15:0] PTXOE_REG_RESET   = 16'h0000;

    // Control register fields
    localparam int PTXOE_M_SRC_LSB    = 3;
    localparam int PTXOE_F1_SRC_LSB   = 1;
    localparam int PTXOE_AUTO_OFF_BIT = 0;

    // Error insertion register fields
    localparam int PTXOE_REI_MAX_BIT   = 13;
    localparam int PTXOE_REI_CONT_BIT  = 12;
    localparam int PTXOE_REI_EN_BIT    = 11;
    localparam int PTXOE_PAR_BLK_BIT   = 10;
    localparam int PTXOE_PAR_CONT_BIT  = 9;
    localparam int PTXOE_PAR_EN_BIT    = 8;
    localparam int PTXOE_FRM_BYTE_BIT  = 5;
    localparam int PTXOE_FRM_TYPE_LSB  = 3;
    localparam int PTXOE_FRM_EN_BIT    = 2;
    localparam int PTXOE_SINGLE_BIT    = 1;
    localparam int PTXOE_TRIG_SRC_BIT  = 0;

    // Source and type codes
    localparam logic [1:0] PTXOE_SRC_00 = 2'h0;
    localparam logic [1:0] PTXOE_SRC_01 = 2'h1;
    localparam logic [1:0] PTXOE_SRC_10 = 2'h2;
    localparam logic [1:0] PTXOE_SRC_11 = 2'h3;
    localparam logic [3:0] PTXOE_REI_ONE   = 4'h1;
    localparam logic [3:0] PTXOE_REI_EIGHT = 4'h8;
    localparam logic [7:0] PTXOE_FLIP_BIT  = 8'h01;
    localparam logic [7:0] PTXOE_FLIP_ALL  = 8'hff;

    // Overhead slot codes carried with each stream byte
    typedef enum logic [3:0] {
        PTXOE_SLOT_PAY = 4'h0,
        PTXOE_SLOT_A1  = 4'h1,
        PTXOE_SLOT_A2  = 4'h2,
        PTXOE_SLOT_POI = 4'h3,
        PTXOE_SLOT_B1  = 4'h4,
        PTXOE_SLOT_G1  = 4'h5,
        PTXOE_SLOT_F1  = 4'h6,
        PTXOE_SLOT_M1  = 4'h7,
        PTXOE_SLOT_M2  = 4'h8,
        PTXOE_SLOT_Z   = 4'h9
    } ptxoe_slot_e;

    typedef struct packed {
        logic        valid;
        ptxoe_slot_e slot;
        logic [7:0]  data;
    } ptxoe_byte_s;

    typedef enum logic [2:0] {
        PTXOE_FS_IDLE   = 3'b001,
        PTXOE_FS_ARMED  = 3'b010,
        PTXOE_FS_SECOND = 3'b100
    } ptxoe_frm_e;

endpackage

//--- ptxoe_hdlc_src.sv
`timescale 1ns/1ps
`default_nettype none
module ptxoe_hdlc_src (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       take_i,
    output logic [7:0]      byte_o
);
    // Next byte once the framer has consumed one; odd step keeps bytes distinct
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            byte_o <= 8'h21;
        end else if (take_i) begin
            byte_o <= byte_o + 8'h13;
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ptxoe_pkg::*;
    logic        clk_i        = 1'b0;
    logic        arst_n_i     = 1'b0;
    logic [8:0]  addr_i       = 9'h000;
    logic [15:0] wr_data_i    = 16'h0000;
    logic        wr_i         = 1'b0;
    logic        rd_i         = 1'b0;
    logic [15:0] rd_data_o;
    ptxoe_byte_s stream_i     = '0;
    ptxoe_byte_s stream_o;
    logic [7:0]  hdlc_byte_i;
    logic        hdlc_take_o;
    logic [7:0]  trace_byte_i = 8'h5a;
    logic [3:0]  rx_bip_err_i = 4'h3;
    logic        manual_pin   = 1'b0;
    int          num_errors   = 0;
    int          n_tests      = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    ptxoe_top uut (
        .clk_i              (clk_i),
        .arst_n_i           (arst_n_i),
        .addr_i             (addr_i),
        .wr_data_i          (wr_data_i),
        .wr_i               (wr_i),
        .rd_i               (rd_i),
        .rd_data_o          (rd_data_o),
        .stream_i           (stream_i),
        .stream_o           (stream_o),
        .hdlc_byte_i        (hdlc_byte_i),
        .hdlc_take_o        (hdlc_take_o),
        .trace_byte_i       (trace_byte_i),
        .rx_bip_err_i       (rx_bip_err_i),
        .manual_error_pin_i (manual_pin)
    );

    ptxoe_hdlc_src u_hdlc (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .take_i   (hdlc_take_o),
        .byte_o   (hdlc_byte_i)
    );

    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        chk16({8'h00, g}, {8'h00, e});
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data only in the cycle after the strobe
    task automatic rdchk(input logic [8:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk16(rd_data_o, e);
    endtask

    // Injection config with trigger low, then a rising trigger bit
    task automatic arm(input logic [15:0] c);
        wr(9'h148, c);
        wr(9'h148, c | 16'h0002);
    endtask

    // One stream byte; output checked one cycle later, hd marks HDLC sourcing
    task automatic xfer(input ptxoe_slot_e s, input logic [7:0] d,
                        input logic [7:0] e, input logic hd);
        logic [7:0] x;
        @(posedge clk_i);
        stream_i <= '{1'b1, s, d};
        #1 x = hd ? hdlc_byte_i : e;
        @(posedge clk_i);
        stream_i.valid <= 1'b0;
        #1 chk8(stream_o.data, x);
        chk8({7'h00, hdlc_take_o}, {7'h00, hd});
        chk8({3'h0, stream_o.valid, stream_o.slot}, {4'h1, s});
    endtask

    task automatic t_regs;
        rdchk(9'h140, 16'h0000);
        rdchk(9'h148, 16'h0000);
        rdchk(9'h178, 16'h0008);
        wr(9'h140, 16'hffff);
        rdchk(9'h140, 16'h001f);
        wr(9'h160, 16'hbeef);
        rdchk(9'h160, 16'hbeef);
        wr(9'h148, 16'hffff);
        rdchk(9'h148, 16'h3f3f);
        wr(9'h148, 16'h0000);
        rdchk(9'h1fc, 16'h0000);
        @(posedge clk_i);
        #1 chk16(rd_data_o, 16'h0000);
        $display("done: registers");
    endtask

    task automatic t_src;
        int m;
        int f;
        wr(9'h150, 16'ha5c7);
        wr(9'h158, 16'h3c96);
        for (m = 0; m < 4; m++) begin
            for (f = 0; f < 4; f++) begin
                wr(9'h140, {11'h000, m[1:0], f[1:0], 1'b0});
                xfer(PTXOE_SLOT_F1, 8'h00, (f == 0) ? 8'h5a : ((f == 1) ? 8'h00 : 8'ha5),
                     (f == 1) && (m != 0));
                xfer(PTXOE_SLOT_M1, 8'h00, 8'h96, m[0] == 1'b0);
                xfer(PTXOE_SLOT_M2, 8'h00, 8'h3c, m[1] == 1'b0);
            end
        end
        $display("done: sources");
    endtask

    task automatic t_rei;
        wr(9'h140, 16'h0000);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'h37, 1'b0);
        wr(9'h140, 16'h0001);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'hc7, 1'b0);
        arm(16'h0800);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'h17, 1'b0);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'hc7, 1'b0);
        arm(16'h2800);
        arm(16'h2800);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'h87, 1'b0);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'hc7, 1'b0);
        arm(16'h0000);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'hc7, 1'b0);
        wr(9'h148, 16'h1800);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'h17, 1'b0);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'h17, 1'b0);
        wr(9'h148, 16'h0000);
        xfer(PTXOE_SLOT_G1, 8'h00, 8'hc7, 1'b0);
        $display("done: remote error");
    endtask

    task automatic t_par;
        arm(16'h0100);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5d, 1'b0);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5c, 1'b0);
        arm(16'h0500);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'ha3, 1'b0);
        arm(16'h0000);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5c, 1'b0);
        wr(9'h148, 16'h0300);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5d, 1'b0);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5d, 1'b0);
        wr(9'h148, 16'h0000);
        $display("done: parity");
    endtask

    task automatic t_frm;
        arm(16'h0004);
        xfer(PTXOE_SLOT_A1, 8'hf6, 8'hf7, 1'b0);
        xfer(PTXOE_SLOT_A2, 8'h28, 8'h28, 1'b0);
        arm(16'h002c);
        xfer(PTXOE_SLOT_POI, 8'h11, 8'hee, 1'b0);
        xfer(PTXOE_SLOT_POI, 8'h11, 8'h11, 1'b0);
        arm(16'h0034);
        xfer(PTXOE_SLOT_A1, 8'hf6, 8'h09, 1'b0);
        xfer(PTXOE_SLOT_A2, 8'h28, 8'hd7, 1'b0);
        xfer(PTXOE_SLOT_A1, 8'hf6, 8'hf6, 1'b0);
        arm(16'h001c);
        xfer(PTXOE_SLOT_POI, 8'h11, 8'h10, 1'b0);
        xfer(PTXOE_SLOT_POI, 8'h11, 8'h10, 1'b0);
        xfer(PTXOE_SLOT_POI, 8'h11, 8'h11, 1'b0);
        arm(16'h0000);
        xfer(PTXOE_SLOT_A1, 8'hf6, 8'hf6, 1'b0);
        $display("done: framing");
    endtask

    task automatic t_pin;
        wr(9'h148, 16'h0101);
        wr(9'h148, 16'h0103);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5c, 1'b0);
        wr(9'h148, 16'h0101);
        @(posedge clk_i);
        manual_pin <= 1'b1;
        repeat (6) @(posedge clk_i);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5d, 1'b0);
        xfer(PTXOE_SLOT_B1, 8'h5c, 8'h5c, 1'b0);
        @(posedge clk_i);
        manual_pin <= 1'b0;
        $display("done: pin trigger");
    endtask

    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_src();
        t_rei();
        t_par();
        t_frm();
        t_pin();
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
